//--- csfr_core_model.sv
// execution core model issuing data-memory accesses
module csfr_core_model
  import csfr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output csfr_pkg::csfr_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // one write, held over its taking edge, then an idle cycle
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    o_req = '{rd: 1'b0, wr: 1'b1, indirect: 1'b0, addr: addr, wdata: data};
    @(posedge i_sys_clk) #1;
    o_req = '0;
    @(posedge i_sys_clk) #1;
  endtask
  // one read; a missing answer comes back unknown
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    o_req = '{rd: 1'b1, wr: 1'b0, indirect: 1'b0, addr: addr, wdata: 8'h00};
    @(posedge i_sys_clk) #1;
    o_req = '0;
    for (int n = 0; n < 4; n++) begin
      @(posedge i_sys_clk) #1;
      if (i_rvalid === 1'b1) break;
    end
    data = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
  endtask
  // no register-to-register path, so a move goes through the accumulator
  task automatic move_reg(input logic [7:0] src, input logic [7:0] dst);
    logic [7:0] v;
    read_reg(src, v);
    write_reg(OFS_ALU, v);
    write_reg(dst, v);
  endtask
endmodule // csfr_core_model

//--- csfr_core_regs.sv
// core special-function registers with indirect addressing and bank selection
module csfr_core_regs #(
  parameter bit LARGE_VARIANT = 1'b1 // 1: two-bit bank field, 0: one bit
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire csfr_pkg::csfr_req_t i_req,
  input wire csfr_pkg::csfr_flag_upd_t i_flag_upd,
  input wire csfr_pkg::csfr_sys_evt_t i_sys_evt,
  input wire logic i_tbl_done,
  input wire logic [7:0] i_tbl_high,
  input wire logic i_pd_wdt_rst_n,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [7:0] o_alu_value,
  output logic [7:0] o_bank,
  output logic [15:0] o_tbl_ptr,
  output logic o_pcl_load,
  output logic [7:0] o_pcl_value,
  output logic o_dummy_cycle,
  output logic [7:0] o_flags
);
  import csfr_pkg::*;

  logic [7:0] ptr0; // section-0 pointer
  logic [7:0] ptr1l, ptr1h, ptr2l, ptr2h; // full-range pointer pairs
  logic [7:0] alu_result_holder;
  logic [7:0] program_counter_low;
  logic [7:0] table_pointer_low, table_pointer_high, table_result_high;
  logic [7:0] flag_register;
  logic [7:0] bank_selector;
  csfr_pc_state_t pc_state, next_pc_state;
  logic is_port; // request names an indirect port
  logic [ADDR_W-1:0] eff_addr; // resolved memory address
  logic [7:0] eff_off; // low byte of resolved address
  logic eff_core; // resolved low byte falls on a core register, whatever the section
  logic eff_nop; // indirect resolves to a port itself
  logic ram_we;
  logic [7:0] ram_rdata;
  logic rd_core_q, rd_nop_q, rd_q;
  logic [7:0] core_rdata_q;
  logic [7:0] bank_mask;

  // valid-bit mask of the bank selector by variant
  assign bank_mask = LARGE_VARIANT ? BANK_MASK_LARGE : BANK_MASK_SMALL;

  // is this offset one of the three indirect ports
  function automatic logic port_addr(input logic [7:0] a);
    return (a == OFS_PORT0) || (a == OFS_PORT1) || (a == OFS_PORT2);
  endfunction

  // is this offset one of the core registers
  function automatic logic core_addr(input logic [7:0] a);
    return a <= OFS_CORE_LAST;
  endfunction

  // full address from a section byte and an offset
  function automatic logic [ADDR_W-1:0] mk_addr(input logic [7:0] sec, input logic [7:0] a);
    return {sec[ADDR_W-9:0], a};
  endfunction

  // address resolution: ports follow their pointers, direct goes to section 0
  always_comb begin
    is_port = port_addr(i_req.addr);
    if (i_req.addr == OFS_PORT0) begin
      eff_addr = mk_addr(SECTION0, ptr0);
    end else if (i_req.addr == OFS_PORT1) begin
      eff_addr = mk_addr(ptr1h, ptr1l);
    end else if (i_req.addr == OFS_PORT2) begin
      eff_addr = mk_addr(ptr2h, ptr2l);
    end else begin
      eff_addr = mk_addr(SECTION0, i_req.addr);
    end
    eff_off = eff_addr[7:0];
    // core registers exist only once, seen at the same offsets in every section
    eff_core = core_addr(eff_off);
    eff_nop = is_port && port_addr(eff_off);
  end

  // memory write for everything outside the core group
  assign ram_we = i_req.wr && !eff_core;

  // backing data memory
  csfr_ram u_ram (
    .i_sys_clk(i_sys_clk),
    .i_we(ram_we),
    .i_addr(eff_addr),
    .i_wdata(i_req.wdata),
    .o_rdata(ram_rdata)
  );

  // core write strobe for one offset, blocked for port self-reference
  function automatic logic core_wr(input logic [7:0] off, input logic [7:0] tgt,
                                   input logic wr, input logic core, input logic nop);
    return wr && core && !nop && (off == tgt);
  endfunction

  // memory pointers, ordinary read-write storage
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr0 <= REG_RST;
      ptr1l <= REG_RST;
      ptr1h <= REG_RST;
      ptr2l <= REG_RST;
      ptr2h <= REG_RST;
    end else begin
      if (core_wr(eff_off, OFS_PTR0, i_req.wr, eff_core, eff_nop)) ptr0 <= i_req.wdata;
      if (core_wr(eff_off, OFS_PTR1L, i_req.wr, eff_core, eff_nop)) ptr1l <= i_req.wdata;
      if (core_wr(eff_off, OFS_PTR1H, i_req.wr, eff_core, eff_nop)) ptr1h <= i_req.wdata;
      if (core_wr(eff_off, OFS_PTR2L, i_req.wr, eff_core, eff_nop)) ptr2l <= i_req.wdata;
      if (core_wr(eff_off, OFS_PTR2H, i_req.wr, eff_core, eff_nop)) ptr2h <= i_req.wdata;
    end
  end

  // accumulator: data moves between user registers pass through here
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      alu_result_holder <= REG_RST;
    end else if (core_wr(eff_off, OFS_ALU, i_req.wr, eff_core, eff_nop)) begin
      alu_result_holder <= i_req.wdata;
    end
  end

  // table pointers and table result high byte
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      table_pointer_low <= REG_RST;
      table_pointer_high <= REG_RST;
      table_result_high <= REG_RST;
    end else begin
      if (core_wr(eff_off, OFS_TPTRL, i_req.wr, eff_core, eff_nop)) begin
        table_pointer_low <= i_req.wdata;
      end
      if (core_wr(eff_off, OFS_TPTRH, i_req.wr, eff_core, eff_nop)) begin
        table_pointer_high <= i_req.wdata;
      end
      // read-only to software; only a completed table read loads it
      if (i_tbl_done) begin
        table_result_high <= i_tbl_high;
      end
    end
  end

  // program counter low: a write requests an in-page jump
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      program_counter_low <= REG_RST;
      o_pcl_load <= 1'b0;
    end else begin
      o_pcl_load <= core_wr(eff_off, OFS_PCL, i_req.wr, eff_core, eff_nop);
      if (core_wr(eff_off, OFS_PCL, i_req.wr, eff_core, eff_nop)) begin
        program_counter_low <= i_req.wdata;
      end
    end
  end

  // dummy-cycle sequencer after a counter-low load
  always_comb begin
    next_pc_state = CSFR_RUN;
    unique case (pc_state)
      CSFR_RUN: next_pc_state = o_pcl_load ? CSFR_DUMMY : CSFR_RUN;
      CSFR_DUMMY: next_pc_state = CSFR_RUN; // exactly one inserted cycle
    endcase
  end

  // sequencer state
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_state <= CSFR_RUN;
    end else begin
      pc_state <= next_pc_state;
    end
  end

  assign o_dummy_cycle = (pc_state == CSFR_DUMMY);

  // bank selector: reset has no power-down exception on the async path,
  // so a power-down watchdog reset is handled as a synchronous event
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_selector <= BANK_RST;
    end else if (!i_pd_wdt_rst_n) begin
      bank_selector <= bank_selector;
    end else if (core_wr(eff_off, OFS_BANK, i_req.wr, eff_core, eff_nop)) begin
      bank_selector <= i_req.wdata & bank_mask;
    end
  end

  // flag register: alu updates, software writes, system events
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_register <= FLAGS_RST;
    end else begin
      // software write spares watchdog and halted flags
      if (core_wr(eff_off, OFS_FLAGS, i_req.wr, eff_core, eff_nop)) begin
        flag_register <= (flag_register & ~FLAGS_SW_MASK)
                       | (i_req.wdata & FLAGS_SW_MASK);
      end
      // alu outcome overrides a same-cycle software write on affected bits
      for (int b = 0; b < 8; b++) begin
        if (i_flag_upd.mask[b] && FLAGS_SW_MASK[b]) begin
          flag_register[b] <= i_flag_upd.value[b];
        end
      end
      // protected flags: clear events first, timeout set wins
      if (i_sys_evt.wdt_clear) begin
        flag_register[FB_TO] <= 1'b0;
        flag_register[FB_PD] <= 1'b0;
      end
      if (i_sys_evt.halt) begin
        flag_register[FB_TO] <= 1'b0;
        flag_register[FB_PD] <= 1'b1;
      end
      if (i_sys_evt.wdt_timeout) begin
        flag_register[FB_TO] <= 1'b1;
      end
    end
  end

  // core register read mux
  function automatic logic [7:0] core_read(input logic [7:0] a);
    unique case (a)
      OFS_PTR0: return ptr0;
      OFS_PTR1L: return ptr1l;
      OFS_PTR1H: return ptr1h;
      OFS_ALU: return alu_result_holder;
      OFS_PCL: return program_counter_low;
      OFS_TPTRL: return table_pointer_low;
      OFS_TRESH: return table_result_high;
      OFS_TPTRH: return table_pointer_high;
      OFS_FLAGS: return flag_register;
      OFS_BANK: return bank_selector;
      OFS_PTR2L: return ptr2l;
      OFS_PTR2H: return ptr2h;
      default: return 8'h00; // ports themselves hold nothing
    endcase
  endfunction

  // capture read path so it lines up with the memory latency
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_q <= 1'b0;
      rd_core_q <= 1'b0;
      rd_nop_q <= 1'b0;
      core_rdata_q <= 8'h00;
    end else begin
      rd_q <= i_req.rd;
      rd_core_q <= eff_core;
      rd_nop_q <= eff_nop;
      core_rdata_q <= core_read(eff_off);
    end
  end

  // read data: zero for a port self-reference
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= rd_q;
      if (rd_nop_q) begin
        o_rdata <= 8'h00;
      end else if (rd_core_q) begin
        o_rdata <= core_rdata_q;
      end else begin
        o_rdata <= ram_rdata;
      end
    end
  end

  assign o_alu_value = alu_result_holder;
  assign o_bank = bank_selector;
  assign o_tbl_ptr = {table_pointer_high, table_pointer_low};
  assign o_pcl_value = program_counter_low;
  assign o_flags = flag_register;
endmodule // csfr_core_regs

//--- csfr_core_regs_monitor.sv
// port-level assertion checker for the core register group
module csfr_core_regs_monitor
  import csfr_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1 // must match the bound design
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_pd_wdt_rst_n,
  input wire csfr_pkg::csfr_req_t i_req,
  input wire csfr_pkg::csfr_flag_upd_t i_flag_upd,
  input wire csfr_pkg::csfr_sys_evt_t i_sys_evt,
  input wire logic o_rvalid,
  input wire logic [7:0] o_bank,
  input wire logic o_pcl_load,
  input wire logic [7:0] o_pcl_value,
  input wire logic o_dummy_cycle,
  input wire logic [7:0] o_flags
);
  localparam logic [7:0] BMASK = LARGE_VARIANT ? BANK_MASK_LARGE : BANK_MASK_SMALL;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // no event this cycle, so the protected flags have no cause to move
  logic quiet;
  assign quiet = !(i_sys_evt.wdt_timeout || i_sys_evt.wdt_clear || i_sys_evt.halt);
  // direct write of the program counter low byte
  sequence s_pcl_wr;
    i_req.wr && i_req.addr == OFS_PCL;
  endsequence
  // the jump pulse followed by the dummy cycle
  sequence s_jump;
    o_pcl_load ##1 o_dummy_cycle;
  endsequence
  property p_read_answer;
    i_req.rd |-> ##2 o_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  property p_jump;
    s_pcl_wr |=> s_jump and (o_pcl_value == $past(i_req.wdata));
  endproperty
  a_jump: assert property (p_jump) else $error("jump or dummy cycle wrong");
  property p_bank_wr;
    i_req.wr && i_req.addr == OFS_BANK && i_pd_wdt_rst_n
      |=> o_bank == ($past(i_req.wdata) & BMASK);
  endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("bank write wrong");
  // power-down watchdog reset freezes the bank selector
  property p_bank_hold;
    !i_pd_wdt_rst_n |=> $stable(o_bank);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank moved in power-down reset");
  property p_bank_pad;
    (o_bank & ~BMASK) == 8'h00;
  endproperty
  a_bank_pad: assert property (p_bank_pad) else $error("bank upper bits set");
  property p_timeout;
    i_sys_evt.wdt_timeout |=> o_flags[FB_TO];
  endproperty
  a_timeout: assert property (p_timeout) else $error("watchdog flag not set");
  property p_halt;
    i_sys_evt.halt && !i_sys_evt.wdt_timeout |=> o_flags[FB_PD] && !o_flags[FB_TO];
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_clear;
    i_sys_evt.wdt_clear && !i_sys_evt.halt && !i_sys_evt.wdt_timeout
      |=> o_flags[FB_TO:FB_PD] == 2'b00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear flags wrong");
  property p_protect;
    quiet |=> $stable(o_flags[FB_TO:FB_PD]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected flag moved");
  property p_alu;
    i_flag_upd.mask != 8'h00 |=> ((o_flags ^ $past(i_flag_upd.value))
      & $past(i_flag_upd.mask) & FLAGS_SW_MASK) == 8'h00;
  endproperty
  a_alu: assert property (p_alu) else $error("flag update lost");
endmodule // csfr_core_regs_monitor

bind csfr_core_regs csfr_core_regs_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) u_mon (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_pd_wdt_rst_n(i_pd_wdt_rst_n),
  .i_req(i_req), .i_flag_upd(i_flag_upd),
  .i_sys_evt(i_sys_evt), .o_rvalid(o_rvalid), .o_bank(o_bank), .o_pcl_load(o_pcl_load),
  .o_pcl_value(o_pcl_value), .o_dummy_cycle(o_dummy_cycle), .o_flags(o_flags));

//--- csfr_core_regs_test.sv
// self-checking bench for the core register group
module csfr_core_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csfr_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  csfr_req_t req;
  csfr_flag_upd_t flag_upd = '0;
  csfr_sys_evt_t sys_evt = '0;
  logic tbl_done = 1'b0;
  logic [7:0] tbl_high = 8'h00;
  logic pd_wdt_rst_n = 1'b1;
  logic rvalid, pcl_load, dummy_cycle;
  logic [7:0] rdata, alu_value, bank, pcl_value, flags, got, v, m;
  logic [15:0] tbl_ptr;
  logic [7:0] exp_reg [15]; // expected register contents
  logic [31:0] seed = 32'h6A7D;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  logic [3:0] ev_tab [4] = '{4'h8, 4'h2, 4'hA, 4'h4}; // timeout, halt, both, clear
  logic [1:0] fl_tab [4] = '{2'b10, 2'b01, 2'b11, 2'b00}; // watchdog, halted
  always #20 sys_clk = ~sys_clk;
  csfr_core_model u_csfr_core_model (.i_sys_clk(sys_clk), .i_rvalid(rvalid),
    .i_rdata(rdata), .o_req(req));
  csfr_core_regs #(.LARGE_VARIANT(1'b1)) u_csfr_core_regs (.i_sys_clk(sys_clk),
    .i_resetn(resetn), .i_req(req), .i_flag_upd(flag_upd), .i_sys_evt(sys_evt),
    .i_tbl_done(tbl_done), .i_tbl_high(tbl_high), .i_pd_wdt_rst_n(pd_wdt_rst_n),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_alu_value(alu_value), .o_bank(bank),
    .o_tbl_ptr(tbl_ptr), .o_pcl_load(pcl_load), .o_pcl_value(pcl_value),
    .o_dummy_cycle(dummy_cycle), .o_flags(flags));
  // next random byte from the shift register
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // what a write leaves readable at a core offset
  function automatic logic [7:0] wmask(input int a, input logic [7:0] d);
    case (a)
      8: return 8'h00; // table result ignores writes
      10: return d & FLAGS_SW_MASK; // protected flags still clear
      11: return d & BANK_MASK_LARGE;
      default: return d;
    endcase
  endfunction
  // flags after an alu update
  function automatic logic [7:0] exp_flags(input logic [7:0] o, mk, d);
    return (o & ~(mk & FLAGS_SW_MASK)) | (d & mk & FLAGS_SW_MASK);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk) #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_csfr_core_model.write_reg(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
    u_csfr_core_model.read_reg(a, got);
    check(16'(got), 16'(want));
  endtask
  task automatic pulse_evt(input csfr_sys_evt_t e);
    sys_evt = e;
    step();
    sys_evt = '0;
    step();
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 resetn = 1'b1;
    step();
    for (int a = 0; a <= 14; a++) begin
      rd_chk(8'(a), 8'h00);
    end
    $display("test reset_values done");
    // write core offsets 1 to 14 except the ports and the counter low byte with noise and read them back
    for (int a = 1; a <= 14; a++) begin
      if (a == 2 || a == 6 || a == 12) continue;
      v = rnd();
      exp_reg[a] = wmask(a, v);
      wr(8'(a), v);
      rd_chk(8'(a), exp_reg[a]);
    end
    check(tbl_ptr, {exp_reg[9], exp_reg[7]});
    check(16'(alu_value), 16'(exp_reg[5]));
    $display("test readback done");
    // indirect ports through each pointer, section 1 only via ports one and two
    v = rnd();
    wr(OFS_PTR0, 8'h40);
    wr(OFS_PORT0, v);
    rd_chk(8'h40, v);
    wr(OFS_PTR1H, 8'h01);
    wr(OFS_PTR1L, 8'h40);
    wr(OFS_PORT1, ~v);
    rd_chk(OFS_PORT1, ~v);
    rd_chk(8'h40, v);
    wr(OFS_PTR2H, 8'h01);
    wr(OFS_PTR2L, 8'h40);
    rd_chk(OFS_PORT2, ~v);
    wr(OFS_PTR0, OFS_PORT2);
    wr(OFS_PORT0, rnd());
    rd_chk(OFS_PORT0, 8'h00);
    u_csfr_core_model.move_reg(8'h40, OFS_PTR2L);
    rd_chk(OFS_PTR2L, v);
    $display("test indirect done");
    // jumps within the page, each followed by a dummy cycle
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : rnd();
      wr(OFS_PCL, v);
      check(16'(pcl_value), 16'(v));
      check(16'(dummy_cycle), 16'h0001);
      check(16'(pcl_load), 16'h0000);
    end
    $display("test jump done");
    // system events against the two protected flags
    for (int i = 0; i < 4; i++) begin
      pulse_evt(ev_tab[i]);
      check(16'(flags[5:4]), 16'(fl_tab[i]));
    end
    pulse_evt(4'h8);
    wr(OFS_FLAGS, 8'hFF);
    check(16'(flags), 16'h00EF);
    $display("test status events done");
    // random alu flag updates
    for (int i = 0; i < 24; i++) begin
      m = (i == 0) ? 8'hFF : rnd();
      v = (i == 0) ? 8'h00 : rnd();
      got = exp_flags(flags, m, v);
      flag_upd = '{mask: m, value: v};
      step();
      flag_upd = '0;
      step();
      check(16'(flags), 16'(got));
    end
    tbl_high = rnd();
    tbl_done = 1'b1;
    step();
    tbl_done = 1'b0;
    step();
    rd_chk(OFS_TRESH, tbl_high);
    $display("test flags and table done");
    // watchdog reset in power-down keeps the bank, a plain reset clears it
    wr(OFS_BANK, 8'h02);
    check(16'(bank), 16'h0002);
    // the power-down watchdog reset arrives on its own pin; a write meanwhile must not land
    pd_wdt_rst_n = 1'b0;
    wr(OFS_BANK, 8'h01);
    pd_wdt_rst_n = 1'b1;
    check(16'(bank), 16'h0002);
    resetn = 1'b0;
    step();
    resetn = 1'b1;
    step();
    check(16'(bank), 16'h0000);
    $display("test bank reset done");
    final_report();
  end
endmodule // csfr_core_regs_test

//--- csfr_pkg.sv
// constants and carrier types for the core special-function register group
package csfr_pkg;
  localparam int ADDR_W = 12; // 16 sections of 256 bytes at most
  localparam logic [7:0] OFS_PORT0 = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h01;
  localparam logic [7:0] OFS_PORT1 = 8'h02;
  localparam logic [7:0] OFS_PTR1L = 8'h03;
  localparam logic [7:0] OFS_PTR1H = 8'h04;
  localparam logic [7:0] OFS_ALU = 8'h05;
  localparam logic [7:0] OFS_PCL = 8'h06;
  localparam logic [7:0] OFS_TPTRL = 8'h07;
  localparam logic [7:0] OFS_TRESH = 8'h08;
  localparam logic [7:0] OFS_TPTRH = 8'h09;
  localparam logic [7:0] OFS_FLAGS = 8'h0A;
  localparam logic [7:0] OFS_BANK = 8'h0B;
  localparam logic [7:0] OFS_PORT2 = 8'h0C;
  localparam logic [7:0] OFS_PTR2L = 8'h0D;
  localparam logic [7:0] OFS_PTR2H = 8'h0E;
  localparam logic [7:0] OFS_CORE_LAST = 8'h0E;
  // flag register bit positions
  localparam int FB_C = 0;
  localparam int FB_AC = 1;
  localparam int FB_Z = 2;
  localparam int FB_OV = 3;
  localparam int FB_PD = 4;
  localparam int FB_TO = 5;
  localparam int FB_CZ = 6;
  localparam int FB_SC = 7;
  localparam logic [7:0] FLAGS_SW_MASK = 8'hCF; // all but watchdog/halted
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] BANK_MASK_SMALL = 8'h01;
  localparam logic [7:0] BANK_MASK_LARGE = 8'h03;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] SECTION0 = 8'h00;

  // core data-memory access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic indirect; // address came from an instruction operand referencing a port
    logic [7:0] addr;
    logic [7:0] wdata;
  } csfr_req_t;

  // alu flag update request
  typedef struct packed {
    logic [7:0] mask; // which flag bits this operation affects
    logic [7:0] value;
  } csfr_flag_upd_t;

  // system events; all but pd_wdt_reset touch the protected flags
  typedef struct packed {
    logic wdt_timeout;
    logic wdt_clear;
    logic halt;
    logic pd_wdt_reset; // watchdog reset while powered down
  } csfr_sys_evt_t;

  typedef enum logic [1:0] {
    CSFR_RUN = 2'b00,
    CSFR_DUMMY = 2'b01
  } csfr_pc_state_t;
endpackage

//--- csfr_ram.sv
// general-purpose data memory with registered read data
module csfr_ram (
  input wire logic i_sys_clk,
  input wire logic i_we,
  input wire logic [csfr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  import csfr_pkg::*;
  logic [7:0] mem [0:(1<<ADDR_W)-1]; // storage, contents unknown at power-up

  // write port
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge i_sys_clk) begin
    o_rdata <= mem[i_addr];
  end
endmodule // csfr_ram
